// ===== tic_pkg.sv
// Package with register map, field layout and reset values of the timer input capture unit
// What this block does
// RL1: Selected edge on a channel pin latches the current free-running count.
// RL2: Edges are synchronised; capture happens on the same clock edge as the count step, latching the pre-step count.
// RL3: The full 16-bit count moves into the capture pair in one transfer.
// RL4: Pin three direction bit resets cleared, making the pin an input.
// RL5: Shared channel captures only while the capture4/compare5 select is set; resets cleared.
// RL6: With pin three an output and capture four on, software-made edges capture.
// RL7: Writes to the shared register are ignored while it serves as capture four.
// RL8: Edge field: 00 off, 01 rising, 10 falling, 11 any edge.
// RL9: Four edge select pairs, one per channel, all reset to zero.
// RL10: Channels capture independently and may latch the same count value.
// RL11: Reset leaves the capture registers untouched.
// RL12: Each capture reads as a high byte and a low byte, both read-only.
// RL13: A high-byte read blocks new transfers into that pair for one cycle.
// RL14: A capture arriving in the same cycle as a high-byte read is held one cycle, not lost.
// RL15: Software reads a capture with one double-byte read for coherency.
// RL16: Channel pairs one, two, three sit at 1010, 1012, 1014, high byte first.
// RL17: Counter starts at zero, counts to all ones, wraps, sets overflow, continues.
// RL18: Counter steps at the clock divided by 1, 4, 8 or 16 from two bits.
// RL19: Each capture sets its flag and raises an interrupt when its mask bit is set.
package tic_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [15:0] TIC_CAP1_HI   = 16'h1010;
  localparam logic [15:0] TIC_CAP1_LO   = 16'h1011;
  localparam logic [15:0] TIC_CAP2_HI   = 16'h1012;
  localparam logic [15:0] TIC_CAP2_LO   = 16'h1013;
  localparam logic [15:0] TIC_CAP3_HI   = 16'h1014;
  localparam logic [15:0] TIC_CAP3_LO   = 16'h1015;
  localparam logic [15:0] TIC_SHARED_HI = 16'h101e;
  localparam logic [15:0] TIC_SHARED_LO = 16'h101f;
  localparam logic [15:0] TIC_EDGE_CTL  = 16'h1021;
  localparam logic [15:0] TIC_MASK      = 16'h1022;
  localparam logic [15:0] TIC_FLAG      = 16'h1023;
  localparam logic [15:0] TIC_ACC_CTL   = 16'h1026;
  localparam logic [15:0] TIC_COUNT_HI  = 16'h100e;
  localparam logic [15:0] TIC_COUNT_LO  = 16'h100f;
  localparam logic [15:0] TIC_PORT_A    = 16'h1000;
  // ==========================================================
  // Field positions and reset values
  localparam int          TIC_DIR3_BIT   = 7;   // pin3_direction_bit in accumulator control
  localparam int          TIC_SEL45_BIT  = 2;   // capture4_compare5_select
  localparam int          TIC_OVF_BIT    = 7;   // Overflow flag in flag register
  localparam logic [7:0]  TIC_ACC_RST    = 8'h00;
  localparam logic [7:0]  TIC_EDGE_RST   = 8'h00;
  localparam logic [7:0]  TIC_MASK_RST   = 8'h00;
  localparam logic [15:0] TIC_SHARED_RST = 16'hffff;
  localparam logic [15:0] TIC_COUNT_RST  = 16'h0000;
  localparam logic [1:0]  TIC_EDGE_OFF   = 2'h0;
  localparam logic [1:0]  TIC_EDGE_RISE  = 2'h1;
  localparam logic [1:0]  TIC_EDGE_FALL  = 2'h2;
  localparam logic [1:0]  TIC_EDGE_ANY   = 2'h3;
  // Prescale taps: divide by 1, 4, 8, 16
  localparam logic [3:0]  TIC_DIV4_MASK  = 4'h3;
  localparam logic [3:0]  TIC_DIV8_MASK  = 4'h7;
  localparam logic [3:0]  TIC_DIV16_MASK = 4'hf;
endpackage : tic_pkg

// ===== tic_cap_if.sv
// Interface carrying per-channel capture strobes and hold requests
`timescale 1ns/1ps
interface tic_cap_if #(
  parameter int NCH = 4
);
  logic [NCH-1:0] edge_hit;  // Synchronised selected edge or held retry
  logic [NCH-1:0] hold;      // High-byte read seen this cycle
  logic [NCH-1:0] load;      // Transfer count into channel
  modport unit (input edge_hit, input hold, output load);
  modport top  (output edge_hit, output hold, input load);
  // Edge unit view: makes strobes and loads, sees the hold requests
  modport sync (output edge_hit, input hold, output load);
endinterface : tic_cap_if

// ===== tic_edge_sync.sv
// Per-channel pin synchroniser and edge detector with hold-and-retry transfer logic
`timescale 1ns/1ps
module tic_edge_sync #(
  parameter int NCH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [NCH-1:0]   pin_in,
  input  wire logic [2*NCH-1:0] edge_sel,
  input  wire logic [NCH-1:0]   ch_en,
  tic_cap_if.sync               cap
);
  import tic_pkg::*;

  logic [NCH-1:0] meta_r;
  logic [NCH-1:0] sync_r;
  logic [NCH-1:0] prev_r;
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] pend_nxt;
  logic [NCH-1:0] hit;

  // ==========================================================
  // Edge decode per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire logic [1:0] sel  = edge_sel[2*i+1:2*i];
    wire logic       rise = sync_r[i] & ~prev_r[i];
    wire logic       fall = ~sync_r[i] & prev_r[i];
    assign hit[i] = ch_en[i] & ((sel[0] & rise) | (sel[1] & fall)); // [RL8] [RL10]
  end

  assign cap.edge_hit = hit | pend_r;
  // Held capture retries next cycle; no edge is dropped
  assign cap.load     = cap.edge_hit & ~cap.hold;                   // [RL13] [RL14]
  assign pend_nxt     = cap.edge_hit & cap.hold;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      pend_r <= '0;
    end else begin
      meta_r <= pin_in;                                             // [RL2]
      sync_r <= meta_r;
      prev_r <= sync_r;
      pend_r <= pend_nxt;
    end
  end
endmodule : tic_edge_sync

// ===== tic_prescale.sv
// Free-running count prescaler producing the count step pulse
`timescale 1ns/1ps
module tic_prescale (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [1:0] rate_sel,
  output logic            step
);
  import tic_pkg::*;

  logic [3:0] div_r;
  logic [3:0] tap;

  // Select divide mask from rate bits
  assign tap  = (rate_sel == 2'h0) ? 4'h0 :
                (rate_sel == 2'h1) ? TIC_DIV4_MASK :
                (rate_sel == 2'h2) ? TIC_DIV8_MASK : TIC_DIV16_MASK;
  assign step = ((div_r & tap) == tap);                            // [RL18]

  // Divider runs continuously
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
endmodule : tic_prescale

// ===== tic_capture_top.sv
// Top of the timer input capture unit: counter, registers, captures and interrupt
`timescale 1ns/1ps
module tic_capture_top #(
  parameter int NCH = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic [2:0]  capture_pin,
  input  wire logic        port_a_pin_three_in,
  output logic             port_a_pin_three_out,
  output logic             port_a_pin_three_oe,
  input  wire logic [1:0]  rate_sel,
  output logic      [15:0] free_running_count,
  output logic             timer_irq
);
  import tic_pkg::*;

  // ==========================================================
  // State
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cap_r [NCH];
  logic [7:0]  acc_ctl_r;
  logic [7:0]  edge_ctl_r;
  logic [7:0]  mask_r;
  logic [7:0]  flag_r;
  logic [7:0]  flag_nxt;
  logic        pin3_out_r;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        irq_r;
  logic        step;

  wire logic   dir3   = acc_ctl_r[TIC_DIR3_BIT];
  wire logic   sel45  = acc_ctl_r[TIC_SEL45_BIT];
  wire logic   shared_wr_hi = bus_wr & (bus_addr == TIC_SHARED_HI);
  wire logic   shared_wr_lo = bus_wr & (bus_addr == TIC_SHARED_LO);

  tic_cap_if #(.NCH(NCH)) cap_bus ();

  tic_prescale u_pre (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .rate_sel (rate_sel),
    .step     (step)
  );

  // ==========================================================
  // Pin three reads driven level when output, external level otherwise
  wire logic [NCH-1:0] pins = {dir3 ? pin3_out_r : port_a_pin_three_in, capture_pin}; // [RL6]
  // Channel four enabled only in capture mode
  wire logic [NCH-1:0] ch_en = {sel45, 3'b111};                    // [RL5]

  // Edge fields: channel one in bits 5:4, two in 3:2, three in 1:0, four in 7:6
  wire logic [2*NCH-1:0] edge_sel = {edge_ctl_r[7:6], edge_ctl_r[1:0],
                                     edge_ctl_r[3:2], edge_ctl_r[5:4]};

  // High-byte read of each pair holds that pair's transfer
  assign cap_bus.hold = {bus_rd & (bus_addr == TIC_SHARED_HI),
                         bus_rd & (bus_addr == TIC_CAP3_HI),
                         bus_rd & (bus_addr == TIC_CAP2_HI),
                         bus_rd & (bus_addr == TIC_CAP1_HI)};        // [RL13]

  tic_edge_sync #(.NCH(NCH)) u_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .pin_in   (pins),
    .edge_sel (edge_sel),
    .ch_en    (ch_en),
    .cap      (cap_bus)
  );

  // ==========================================================
  // Counter: zero out of reset, wraps at all ones
  assign cnt_nxt = step ? cnt_r + 16'h0001 : cnt_r;                // [RL17]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= TIC_COUNT_RST;                                       // [RL17]
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Capture registers: no reset, whole word in one transfer.
  // Count is sampled before its step edge, i.e. the stable value.
  for (genvar i = 0; i < NCH; i++) begin : g_cap
    if (i == NCH - 1) begin : g_shared
      always_ff @(posedge mclk) begin
        if (cap_bus.load[i]) begin
          cap_r[i] <= cnt_r;                                        // [RL1] [RL3] [RL11]
        end else if (!sel45 && shared_wr_hi) begin                  // [RL7]
          cap_r[i][15:8] <= bus_wdata;
        end else if (!sel45 && shared_wr_lo) begin                  // [RL7]
          cap_r[i][7:0] <= bus_wdata;
        end
      end
    end else begin : g_ded
      always_ff @(posedge mclk) begin
        if (cap_bus.load[i]) begin
          cap_r[i] <= cnt_r;                                        // [RL1] [RL3] [RL10] [RL11]
        end
      end
    end
  end

  // ==========================================================
  // Control registers and flag set/clear, set wins over clear
  assign flag_nxt = (flag_r & ~((bus_wr && bus_addr == TIC_FLAG) ? bus_wdata : 8'h00))
                  | {(step && cnt_r == 16'hffff), 3'b000, cap_bus.load}; // [RL17] [RL19]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ctl_r  <= TIC_ACC_RST;                                    // [RL4] [RL5]
      edge_ctl_r <= TIC_EDGE_RST;                                   // [RL9]
      mask_r     <= TIC_MASK_RST;
      flag_r     <= 8'h00;
      pin3_out_r <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == TIC_ACC_CTL) acc_ctl_r <= bus_wdata;
      if (bus_wr && bus_addr == TIC_EDGE_CTL) edge_ctl_r <= bus_wdata;
      if (bus_wr && bus_addr == TIC_MASK) mask_r <= bus_wdata;
      if (bus_wr && bus_addr == TIC_PORT_A) pin3_out_r <= bus_wdata[3];
      flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (bus_addr)
      TIC_CAP1_HI:   rdata_nxt = cap_r[0][15:8];                    // [RL12] [RL16]
      TIC_CAP1_LO:   rdata_nxt = cap_r[0][7:0];
      TIC_CAP2_HI:   rdata_nxt = cap_r[1][15:8];
      TIC_CAP2_LO:   rdata_nxt = cap_r[1][7:0];
      TIC_CAP3_HI:   rdata_nxt = cap_r[2][15:8];
      TIC_CAP3_LO:   rdata_nxt = cap_r[2][7:0];
      TIC_SHARED_HI: rdata_nxt = cap_r[3][15:8];
      TIC_SHARED_LO: rdata_nxt = cap_r[3][7:0];
      TIC_EDGE_CTL:  rdata_nxt = edge_ctl_r;
      TIC_MASK:      rdata_nxt = mask_r;
      TIC_FLAG:      rdata_nxt = flag_r;
      TIC_ACC_CTL:   rdata_nxt = acc_ctl_r;
      TIC_COUNT_HI:  rdata_nxt = cnt_r[15:8];
      TIC_COUNT_LO:  rdata_nxt = cnt_r[7:0];
      TIC_PORT_A:    rdata_nxt = {4'h0, dir3 ? pin3_out_r : port_a_pin_three_in, 3'h0};
      default:       rdata_nxt = 8'h00;
    endcase
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      rdata_r <= bus_rd ? rdata_nxt : 8'h00;
      irq_r   <= |(flag_nxt & mask_r);                              // [RL19]
    end
  end

  assign bus_rdata            = rdata_r;
  assign timer_irq            = irq_r;
  assign free_running_count   = cnt_r;
  assign port_a_pin_three_out = pin3_out_r;
  assign port_a_pin_three_oe  = acc_ctl_r[TIC_DIR3_BIT];            // [RL4]
endmodule : tic_capture_top

// ===== tic_pin_model.sv
// External event source driving the timer input pins
`timescale 1ns/1ps
module tic_pin_model (
  input  wire logic       mclk,
  output logic      [3:0] pin_lvl
);
  // ==========
  // Levels move only just after a clock edge
  initial pin_lvl = 4'h0;
  task automatic drive(input logic [3:0] m, input logic [3:0] v);
    @(posedge mclk);
    pin_lvl <= (pin_lvl & ~m) | (v & m);
  endtask : drive
endmodule : tic_pin_model

// ===== tic_capture_asserts.sv
// Port checker for the timer input capture top
`timescale 1ns/1ps
module tic_capture_asserts
  import tic_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic [2:0]  capture_pin,
  input wire logic        port_a_pin_three_in,
  input wire logic        port_a_pin_three_out,
  input wire logic        port_a_pin_three_oe,
  input wire logic [1:0]  rate_sel,
  input wire logic [15:0] free_running_count,
  input wire logic        timer_irq
);
  // ==========
  // One clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Counter, bus, pin and interrupt relations
  property p_cnt_rst; $rose(rst_b) |-> !free_running_count && !port_a_pin_three_oe; endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("reset state");
  property p_cnt_inc; rate_sel == 2'h0 [*3] |=>
    free_running_count == $past(free_running_count) + 16'h0001; endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count step");
  property p_cnt_div; rate_sel == 2'h3 [*2] ##0 $changed(free_running_count) |=>
    $stable(free_running_count); endproperty
  a_cnt_div: assert property (p_cnt_div) else $error("prescale");
  sequence s_edge_wr; bus_wr && bus_addr == TIC_EDGE_CTL; endsequence
  property p_edge_rb; s_edge_wr ##2 (bus_rd && bus_addr == TIC_EDGE_CTL) |=>
    bus_rdata == $past(bus_wdata, 3); endproperty
  a_edge_rb: assert property (p_edge_rb) else $error("edge readback");
  property p_oe; bus_wr && bus_addr == TIC_ACC_CTL |=>
    port_a_pin_three_oe == $past(bus_wdata[TIC_DIR3_BIT]); endproperty
  a_oe: assert property (p_oe) else $error("direction");
  property p_pa3; bus_wr && bus_addr == TIC_PORT_A |=>
    port_a_pin_three_out == $past(bus_wdata[3]); endproperty
  a_pa3: assert property (p_pa3) else $error("pin write");
  property p_irq_mask; (bus_wr && bus_addr == TIC_MASK && bus_wdata == 8'h00)
    ##1 !(bus_wr && bus_addr == TIC_MASK) |=> !timer_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  property p_irq_clr; bus_wr && bus_addr == TIC_FLAG && bus_wdata == 8'hff |=>
    !timer_irq; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
  // Main scenarios seen
  c_irq: cover property ($rose(timer_irq));
  c_oe: cover property ($rose(port_a_pin_three_oe));
  c_pa3: cover property ($rose(port_a_pin_three_out));
endmodule : tic_capture_asserts
bind tic_capture_top tic_capture_asserts #(.NCH(NCH)) u_asserts (
  .mclk(mclk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .capture_pin(capture_pin),
  .port_a_pin_three_in(port_a_pin_three_in), .port_a_pin_three_out(port_a_pin_three_out),
  .port_a_pin_three_oe(port_a_pin_three_oe), .rate_sel(rate_sel),
  .free_running_count(free_running_count), .timer_irq(timer_irq));

// ===== tb_timer_input_capture.sv
// Self-checking bench for the timer input capture unit
`timescale 1ns/1ps
module tb_timer_input_capture;
  import tic_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [1:0]  rate_sel = 2'h0;
  logic [7:0]  bus_rdata;
  logic [3:0]  pin_lvl;
  logic        pa3_out, pa3_oe, timer_irq;
  logic [15:0] free_running_count, lat;
  wire         pa3_wire = pa3_oe ? pa3_out : pin_lvl[3];
  int          error_cnt = 0;
  int          cmp_count = 0;
  // ==========
  // Clock, pin source and design
  always #20 mclk = ~mclk;
  tic_pin_model drv (.mclk(mclk), .pin_lvl(pin_lvl));
  tic_capture_top dut (
    .mclk(mclk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .capture_pin(pin_lvl[2:0]), .port_a_pin_three_in(pa3_wire),
    .port_a_pin_three_out(pa3_out), .port_a_pin_three_oe(pa3_oe),
    .rate_sel(rate_sel), .free_running_count(free_running_count), .timer_irq(timer_irq));
  // ==========
  // Bus cycles and compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1 cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge mclk);
  endtask : rd
  task automatic rd16(input logic [15:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 16'h1, d[7:0]);
  endtask : rd16
  // ==========
  // Scenarios
  task automatic s_reset();
    logic [7:0] v;
    chk(pa3_oe, 16'h0);
    rd(TIC_ACC_CTL, v);
    chk(v, TIC_ACC_RST);
    rd(TIC_EDGE_CTL, v);
    chk(v, TIC_EDGE_RST);
    wr(TIC_EDGE_CTL, 8'h5a);
    rd(TIC_EDGE_CTL, v);
    chk(v, 8'h5a);
    rate_sel <= 2'h3;
    repeat (40) @(posedge mclk);
    rate_sel <= 2'h0;
  endtask : s_reset
  task automatic s_modes();
    logic [7:0] v;
    for (int m = 0; m < 4; m++) begin
      wr(TIC_EDGE_CTL, 8'(m << 4));
      for (int lv = 1; lv >= 0; lv--) begin
        wr(TIC_FLAG, 8'hff);
        drv.drive(4'h1, 4'(lv));
        repeat (4) @(posedge mclk);
        rd(TIC_FLAG, v);
        chk(v[0], lv ? m[0] : m[1]);
      end
    end
  endtask : s_modes
  task automatic s_capture();
    logic [15:0] b, c1, c2, c3;
    wr(TIC_EDGE_CTL, 8'h15);
    drv.drive(4'h7, 4'h7);
    #1 b = free_running_count;
    repeat (6) @(posedge mclk);
    rd16(TIC_CAP1_HI, c1);
    rd16(TIC_CAP2_HI, c2);
    rd16(TIC_CAP3_HI, c3);
    lat = c1 - b;
    chk(lat, 16'h2);
    chk(c2, c1);
    chk(c3, c1);
    wr(TIC_CAP1_HI, ~c1[15:8]);
    rd16(TIC_CAP1_HI, c2);
    chk(c2, c1);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd16(TIC_CAP1_HI, c2);
    chk(c2, c1);
  endtask : s_capture
  task automatic s_hold();
    logic [15:0] b, c;
    logic [7:0] v;
    wr(TIC_EDGE_CTL, 8'h10);
    drv.drive(4'h1, 4'h0);
    repeat (4) @(posedge mclk);
    drv.drive(4'h1, 4'h1);
    #1 b = free_running_count;
    repeat (2) @(posedge mclk);
    rd(TIC_CAP1_HI, v);
    repeat (4) @(posedge mclk);
    rd16(TIC_CAP1_HI, c);
    chk(c - b, 16'h3);
  endtask : s_hold
  task automatic s_shared();
    logic [15:0] s0, s1;
    logic [7:0] v;
    wr(TIC_EDGE_CTL, 8'hc0);
    wr(TIC_ACC_CTL, 8'h84);
    chk(pa3_oe, 16'h1);
    wr(TIC_FLAG, 8'hff);
    wr(TIC_PORT_A, 8'h08);
    repeat (5) @(posedge mclk);
    rd(TIC_FLAG, v);
    chk(v[3], 16'h1);
    rd16(TIC_SHARED_HI, s0);
    wr(TIC_SHARED_HI, ~s0[15:8]);
    rd16(TIC_SHARED_HI, s1);
    chk(s1, s0);
    wr(TIC_ACC_CTL, 8'h80);
    wr(TIC_FLAG, 8'hff);
    wr(TIC_PORT_A, 8'h00);
    repeat (5) @(posedge mclk);
    rd(TIC_FLAG, v);
    chk(v[3], 16'h0);
  endtask : s_shared
  task automatic s_irq();
    logic [7:0] v;
    wr(TIC_EDGE_CTL, 8'h20);
    wr(TIC_MASK, 8'h01);
    wr(TIC_FLAG, 8'hff);
    drv.drive(4'h1, 4'h0);
    repeat (5) @(posedge mclk);
    chk(timer_irq, 16'h1);
    wr(TIC_FLAG, 8'h01);
    chk(timer_irq, 16'h0);
    wr(TIC_MASK, 8'h00);
    wr(TIC_EDGE_CTL, 8'h10);
    drv.drive(4'h1, 4'h1);
    repeat (5) @(posedge mclk);
    chk(timer_irq, 16'h0);
    rd(TIC_FLAG, v);
    chk(v[0], 16'h1);
  endtask : s_irq
  // ==========
  // Verdict and run control
  task automatic wrap_up();
    $display("Errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    s_reset();
    s_modes();
    s_capture();
    s_hold();
    s_shared();
    s_irq();
    wrap_up();
  end
endmodule : tb_timer_input_capture
